// >>> hw/smtc_pkg.sv
// shared constants and types for the static memory timing commit block
package smtc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [11:0] ADDR_CMD = 12'h010;
    localparam logic [11:0] ADDR_CYCLES = 12'h014;
    localparam logic [11:0] ADDR_OPMODE = 12'h018;
    localparam logic [11:0] ADDR_BUSMODE = 12'h020;
    localparam logic [11:0] ADDR_BANK_CYC0 = 12'h100;
    localparam logic [11:0] ADDR_BANK_OPM0 = 12'h104;
    localparam logic [11:0] BANK_STRIDE = 12'h020;
    localparam logic [11:0] ADDR_STATUS = 12'h030;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CMD_CS_LSB = 23;
    localparam int CMD_TYPE_LSB = 21;
    localparam logic [1:0] CMD_TYPE_UPDATE = 2'h2;
    localparam int OPM_ALE_BIT = 11;
    localparam int OPM_BL_LSB = 3;
    localparam int NUM_BANKS = 4;

    ////////////////////////////////////////////////////////////////////////
    // reset values of committed settings
    localparam logic [19:0] CYCLES_RESET = 20'h2b3cc;
    localparam logic [11:0] OPMODE_RESET = 12'h001;
    localparam logic [2:0] BL_SINGLE = 3'h0;
    localparam logic [2:0] BL_FOUR = 3'h1;
    localparam logic [1:0] MW_16BIT = 2'h1;

    // memory clock is the system clock divided by this
    localparam int MEM_CLK_DIV = 2;

    ////////////////////////////////////////////////////////////////////////
    // timing set in memory clocks
    typedef struct packed {
        logic [2:0] turnaround_time;
        logic [2:0] page_cycle_time;
        logic [2:0] write_pulse_time;
        logic [2:0] oe_delay_time;
        logic [3:0] write_cycle_time;
        logic [3:0] read_cycle_time;
    } smtc_timing_t;

    // operating mode set
    typedef struct packed {
        logic ale_used;
        logic [2:0] read_burst_len;
        logic [1:0] data_bus_width;
    } smtc_mode_t;

    // effective settings of one bank, in system clocks
    typedef struct packed {
        logic [4:0] turnaround_sys;
        logic [4:0] page_cycle_sys;
        logic page_enable;
        logic [4:0] write_pulse_sys;
        logic [4:0] oe_delay_sys;
        logic [5:0] write_cycle_sys;
        logic [5:0] read_cycle_sys;
        logic ale_used;
        logic burst_four;
    } smtc_eff_t;

endpackage : smtc_pkg

// >>> hw/smtc_bank.sv
// committed timing and mode storage of one chip select bank
`timescale 1ns/1ps
module smtc_bank
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // commit
    input wire logic commit,
    input wire smtc_pkg::smtc_timing_t staged_timing,
    input wire smtc_pkg::smtc_mode_t staged_mode,
    // committed values
    output smtc_pkg::smtc_timing_t timing,
    output smtc_pkg::smtc_mode_t mode
);

    // copy staged values only on this bank's commit
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            timing <= smtc_pkg::smtc_timing_t'(smtc_pkg::CYCLES_RESET);
            mode <= smtc_pkg::smtc_mode_t'(smtc_pkg::OPMODE_RESET);
        end
        else if (clk_en && commit)
        begin
            timing <= staged_timing;
            mode <= staged_mode;
        end
    end

endmodule : smtc_bank

// >>> hw/smtc_eff.sv
// converts committed memory-clock settings to system-clock counts
`timescale 1ns/1ps
module smtc_eff
(
    // settings in
    input wire smtc_pkg::smtc_timing_t timing,
    input wire smtc_pkg::smtc_mode_t mode,
    input wire logic mux_mode,
    // effective counts out
    output smtc_pkg::smtc_eff_t eff
);

    // memory clocks to system clocks
    function automatic logic [5:0] to_sys(input logic [4:0] mclk);
        to_sys = 6'(mclk * smtc_pkg::MEM_CLK_DIV);
    endfunction : to_sys

    logic [4:0] wp_mclk;

    // multiplexed mode stretches write pulse by one memory clock
    assign wp_mclk = mux_mode ? 5'(timing.write_pulse_time) + 5'h01
                              : 5'(timing.write_pulse_time);
    assign eff.turnaround_sys = 5'(to_sys(5'(timing.turnaround_time)));
    assign eff.page_cycle_sys = mux_mode ? 5'h00
                                         : 5'(to_sys(5'(timing.page_cycle_time)));
    assign eff.page_enable = !mux_mode;
    assign eff.write_pulse_sys = 5'(to_sys(wp_mclk));
    assign eff.oe_delay_sys = 5'(to_sys(5'(timing.oe_delay_time)));
    assign eff.write_cycle_sys = to_sys(5'(timing.write_cycle_time));
    assign eff.read_cycle_sys = to_sys(5'(timing.read_cycle_time));
    assign eff.ale_used = mode.ale_used;
    assign eff.burst_four = (mode.read_burst_len == smtc_pkg::BL_FOUR);

endmodule : smtc_eff

// >>> hw/smtc_top.sv
// register front end that stages and commits static memory timings
//
// Notes on behaviour
// - command target field bits 25-23 picks bank 0-3; codes 4-7 not allowed.
// - command type bits 22-21 must be 10 to commit; others forbidden.
// - staged timing writes have no effect until the commit command.
// - staged mode writes only take effect on the commit command.
// - turnaround 1-7 memory clocks, code zero prohibited.
// - page cycle 1-7 memory clocks, code zero prohibited.
// - multiplexed mode does no page accesses; page setting ignored.
// - write pulse 1-7 memory clocks, code zero prohibited.
// - multiplexed mode write pulse is one memory clock longer.
// - output enable delay 1-7 memory clocks, code zero prohibited.
// - write cycle 3-15 memory clocks, code zero prohibited.
// - read cycle 2-15 memory clocks, code zero prohibited.
// - all counts are in memory clocks at half system clock.
// - latch strobe bit 11: 0 none for separate, 1 used for multiplexed.
// - burst field 000 single beat, 001 four beats, others reserved.
// - data width field must be 01 for sixteen bits.
// - bus mode bit 0 separate, 1 multiplexed; not changed in operation.
// - each bank has a read-only cycle register of committed values.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module smtc_top
#(
    parameter int NBANKS = smtc_pkg::NUM_BANKS
)
(
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // settings of the bank in use by the waveform engine
    input wire logic [1:0] active_bank,
    output smtc_pkg::smtc_eff_t active_eff,
    output logic mux_mode,
    output logic cmd_error
);

    ////////////////////////////////////////////////////////////////////////
    // staged registers
    smtc_pkg::smtc_timing_t staged_timing_r;
    smtc_pkg::smtc_mode_t staged_mode_r;
    logic [NBANKS-1:0] commit_r;
    logic [1:0] commit_cnt_r;
    smtc_pkg::smtc_timing_t bank_timing [NBANKS];
    smtc_pkg::smtc_mode_t bank_mode [NBANKS];
    smtc_pkg::smtc_eff_t bank_eff [NBANKS];

    logic wr_cmd;
    logic [2:0] cmd_cs;
    logic [1:0] cmd_kind;
    logic cmd_ok;
    logic wr_cycles;
    logic wr_opmode;
    logic wr_busmode;
    logic wr_clear;
    logic [1:0] rd_cyc_idx;
    logic [1:0] rd_opm_idx;
    logic [31:0] cyc_word;
    logic [31:0] opm_word;
    logic [31:0] status_word;
    logic [31:0] rdata_nxt;

    // write strobes of the command, holding and control registers
    assign wr_cmd = reg_wr && (reg_addr == smtc_pkg::ADDR_CMD);
    assign wr_cycles = reg_wr && (reg_addr == smtc_pkg::ADDR_CYCLES);
    assign wr_opmode = reg_wr && (reg_addr == smtc_pkg::ADDR_OPMODE);
    assign wr_busmode = reg_wr && (reg_addr == smtc_pkg::ADDR_BUSMODE);
    assign wr_clear = reg_wr && (reg_addr == smtc_pkg::ADDR_STATUS) && reg_wdata[0];

    // command fields
    assign cmd_cs = reg_wdata[smtc_pkg::CMD_CS_LSB +: 3];
    assign cmd_kind = reg_wdata[smtc_pkg::CMD_TYPE_LSB +: 2];
    // only targets 0-3 with update type are obeyed
    assign cmd_ok = (cmd_cs < 3'(NBANKS)) && (cmd_kind == smtc_pkg::CMD_TYPE_UPDATE);

    // bank number of a per-bank register address, bank zero when nothing matches
    function automatic logic [1:0] bank_index(input logic [11:0] addr, input logic [11:0] base);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = 0; i < smtc_pkg::NUM_BANKS; i++)
        begin
            if (addr == base + 12'(i) * smtc_pkg::BANK_STRIDE)
            begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction : bank_index

    // true when the address is one of the per-bank registers from base on
    function automatic logic bank_match(input logic [11:0] addr, input logic [11:0] base);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < smtc_pkg::NUM_BANKS; i++)
        begin
            if (addr == base + 12'(i) * smtc_pkg::BANK_STRIDE)
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : bank_match

    ////////////////////////////////////////////////////////////////////////
    // staged timing holding register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            staged_timing_r <= smtc_pkg::smtc_timing_t'(smtc_pkg::CYCLES_RESET);
        else if (clk_en && wr_cycles)
            staged_timing_r <= reg_wdata[19:0];
    end

    // staged mode holding register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            staged_mode_r <= smtc_pkg::smtc_mode_t'(smtc_pkg::OPMODE_RESET);
        else if (clk_en && wr_opmode)
        begin
            staged_mode_r.ale_used <= reg_wdata[smtc_pkg::OPM_ALE_BIT];
            staged_mode_r.read_burst_len <= reg_wdata[smtc_pkg::OPM_BL_LSB +: 3];
            staged_mode_r.data_bus_width <= reg_wdata[1:0];
        end
    end

    // bus mode select
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            mux_mode <= 1'b0;
        else if (clk_en && wr_busmode)
            mux_mode <= reg_wdata[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // commit decode: one-hot strobe to the selected bank
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            commit_r <= '0;
        else if (clk_en)
        begin
            commit_r <= '0;
            if (wr_cmd && cmd_ok)
                commit_r[cmd_cs[1:0]] <= 1'b1;
        end
    end

    // sticky flag for forbidden commands, cleared by a status write with bit 0 set
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            cmd_error <= 1'b0;
        else if (clk_en)
        begin
            if (wr_cmd && !cmd_ok)
                cmd_error <= 1'b1;
            else if (wr_clear)
                cmd_error <= 1'b0;
        end
    end

    // commits accepted, wraps
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            commit_cnt_r <= 2'h0;
        else if (clk_en && |commit_r)
            commit_cnt_r <= commit_cnt_r + 2'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // per-bank committed storage and conversion
    for (genvar b = 0; b < NBANKS; b++)
    begin : g_bank
        smtc_bank u_bank
        (
            .clock(clock),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .commit(commit_r[b]),
            .staged_timing(staged_timing_r),
            .staged_mode(staged_mode_r),
            .timing(bank_timing[b]),
            .mode(bank_mode[b])
        );
        smtc_eff u_eff
        (
            .timing(bank_timing[b]),
            .mode(bank_mode[b]),
            .mux_mode(mux_mode),
            .eff(bank_eff[b])
        );
    end

    // settings for the bank the engine is using
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            active_eff <= '0;
        else if (clk_en)
            active_eff <= bank_eff[active_bank];
    end

    ////////////////////////////////////////////////////////////////////////
    // read-back words of the committed bank settings and of the status
    assign rd_cyc_idx = bank_index(reg_addr, smtc_pkg::ADDR_BANK_CYC0);
    assign rd_opm_idx = bank_index(reg_addr, smtc_pkg::ADDR_BANK_OPM0);
    assign cyc_word = {12'h000, bank_timing[rd_cyc_idx]};
    assign opm_word = {20'h00000, bank_mode[rd_opm_idx].ale_used, 5'h00,
                       bank_mode[rd_opm_idx].read_burst_len, 1'b0,
                       bank_mode[rd_opm_idx].data_bus_width};
    assign status_word = {28'h0000000, commit_cnt_r, 1'b0, cmd_error};

    // read multiplexer, zero for idle cycles and unmapped addresses
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd)
        begin
            if (reg_addr == smtc_pkg::ADDR_BUSMODE)
                rdata_nxt = {31'h0000_0000, mux_mode};
            else if (reg_addr == smtc_pkg::ADDR_STATUS)
                rdata_nxt = status_word;
            else if (bank_match(reg_addr, smtc_pkg::ADDR_BANK_CYC0))
                rdata_nxt = cyc_word;
            else if (bank_match(reg_addr, smtc_pkg::ADDR_BANK_OPM0))
                rdata_nxt = opm_word;
        end
    end

    // read data, valid the cycle after the read strobe
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else if (clk_en)
            reg_rdata <= rdata_nxt;
    end

endmodule : smtc_top

// >>> testbench/smtc_props.sv
// assertion checker for the timing commit front end
`timescale 1ns/1ps
module smtc_props
#(
    parameter int NBANKS = smtc_pkg::NUM_BANKS
)
(
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // presented bank settings
    input wire logic [1:0] active_bank,
    input wire smtc_pkg::smtc_eff_t active_eff,
    input wire logic mux_mode,
    input wire logic cmd_error
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // decoded writes
    logic cmd_wr;
    logic mode_wr;
    logic clr_wr;
    logic [1:0] bank_r;
    logic [2:0] quiet_r;
    assign cmd_wr = clk_en && reg_wr && reg_addr == smtc_pkg::ADDR_CMD;
    assign mode_wr = clk_en && reg_wr && reg_addr == smtc_pkg::ADDR_BUSMODE;
    assign clr_wr = clk_en && reg_wr && reg_addr == smtc_pkg::ADDR_STATUS && reg_wdata[0];

    // enabled cycles since anything that may move the settings
    always_ff @(posedge clock)
    begin
        bank_r <= active_bank;
        if (!rst_n || cmd_wr || mode_wr || active_bank != bank_r)
            quiet_r <= 3'h0;
        else if (clk_en && quiet_r != 3'h7)
            quiet_r <= quiet_r + 3'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    property p_rd_idle;
        $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_mode_set;
        mode_wr |=> mux_mode == $past(reg_wdata[0]);
    endproperty
    a_mode_set: assert property (p_mode_set) else $error("bus mode not taken");
    property p_mode_hold;
        !mode_wr |=> $stable(mux_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("bus mode moved");
    property p_bad_cmd;
        cmd_wr && (reg_wdata[25] || reg_wdata[22:21] != smtc_pkg::CMD_TYPE_UPDATE) |=> cmd_error;
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("forbidden command not flagged");
    property p_err_hold;
        cmd_error && !clr_wr |=> cmd_error;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
    property p_page_off;
        $past(clk_en) && $past(mux_mode) && mux_mode
            |-> !active_eff.page_enable && active_eff.page_cycle_sys == 5'h0;
    endproperty
    a_page_off: assert property (p_page_off) else $error("page access in mux mode");
    property p_even;
        {active_eff.turnaround_sys[0], active_eff.oe_delay_sys[0], active_eff.write_pulse_sys[0],
            active_eff.write_cycle_sys[0], active_eff.read_cycle_sys[0]} == 5'h0;
    endproperty
    a_even: assert property (p_even) else $error("count not whole memory clocks");
    property p_mux_pulse;
        $past(clk_en) && $past(mux_mode) && mux_mode |-> active_eff.write_pulse_sys != 5'h0;
    endproperty
    a_mux_pulse: assert property (p_mux_pulse) else $error("mux write pulse empty");
    property p_quiet;
        quiet_r >= 3'h4 |-> $stable(active_eff);
    endproperty
    a_quiet: assert property (p_quiet) else $error("settings moved without commit");

    // main scenarios
    c_commit: cover property (cmd_wr && reg_wdata[22:21] == smtc_pkg::CMD_TYPE_UPDATE);
    c_mux: cover property (mux_mode && active_eff.ale_used);
    c_err: cover property (cmd_error && clr_wr);
endmodule : smtc_props

bind smtc_top smtc_props #(.NBANKS(NBANKS)) i_props (.clock(clock), .rst_n(rst_n),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .active_bank(active_bank),
    .active_eff(active_eff), .mux_mode(mux_mode), .cmd_error(cmd_error));

// >>> testbench/smtc_engine_model.sv
// stand-in for the waveform engine that picks the bank in use
`timescale 1ns/1ps
module smtc_engine_model
(
    // clock
    input wire logic clock,
    // bank selection
    input wire logic [1:0] bank_req,
    output logic [1:0] active_bank = 2'h0
);
    // bank changes right after an edge, held until the next request
    always @(posedge clock)
        active_bank <= bank_req;
endmodule : smtc_engine_model

// >>> testbench/tb_smtc_top.sv
// self-checking bench for the timing commit front end
`timescale 1ns/1ps
module tb_smtc_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] bank_req = 2'h0;
    logic [31:0] reg_rdata;
    logic [1:0] active_bank;
    logic mux_mode;
    logic cmd_error;
    smtc_pkg::smtc_eff_t active_eff;
    logic [31:0] cyc_exp [4];
    logic [31:0] opm_exp [4];
    logic [31:0] rdat;
    int error_cnt = 0;
    int tests_run = 0;

    ////////////////////////////////////////////////////////////////////////
    smtc_top i_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .active_bank(active_bank), .active_eff(active_eff), .mux_mode(mux_mode),
        .cmd_error(cmd_error));
    smtc_engine_model i_eng (.clock(clock), .bank_req(bank_req), .active_bank(active_bank));

    // 4 ns clock
    initial
    begin
        forever #2 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        rdat = reg_rdata;
    endtask : rd

    // legal timings, oe delay plus one within read cycle
    function automatic logic [31:0] tv(int b);
        return {12'h0, 3'(b + 1), 3'(b + 2), 3'(b + 3), 3'(b + 1), 4'(b + 4), 4'(b + 5)};
    endfunction : tv

    function automatic logic [31:0] om(int b);
        return {20'h0, b[0], 5'h0, 2'h0, b[0], 1'b0, smtc_pkg::MW_16BIT};
    endfunction : om

    function automatic logic [31:0] cmd(logic [2:0] cs, logic [1:0] ty);
        return {6'h0, cs, ty, 21'h0};
    endfunction : cmd

    function automatic smtc_pkg::smtc_eff_t eff_exp(logic [31:0] t, logic [31:0] o, logic m);
        smtc_pkg::smtc_eff_t e;
        e.turnaround_sys = {1'b0, t[19:17], 1'b0};
        e.page_cycle_sys = m ? 5'h0 : {1'b0, t[16:14], 1'b0};
        e.page_enable = !m;
        e.write_pulse_sys = {{1'b0, t[13:11]} + {3'h0, m}, 1'b0};
        e.oe_delay_sys = {1'b0, t[10:8], 1'b0};
        e.write_cycle_sys = {1'b0, t[7:4], 1'b0};
        e.read_cycle_sys = {1'b0, t[3:0], 1'b0};
        e.ale_used = o[11];
        e.burst_four = o[5:3] == smtc_pkg::BL_FOUR;
        return e;
    endfunction : eff_exp

    // read back every bank against the model
    task automatic check_banks();
        for (int b = 0; b < 4; b++)
        begin
            rd(smtc_pkg::ADDR_BANK_CYC0 + 12'(b) * smtc_pkg::BANK_STRIDE);
            chk("bank cycles", 64'(cyc_exp[b]), 64'(rdat));
            rd(smtc_pkg::ADDR_BANK_OPM0 + 12'(b) * smtc_pkg::BANK_STRIDE);
            chk("bank opmode", 64'(opm_exp[b]), 64'(rdat));
        end
    endtask : check_banks

    ////////////////////////////////////////////////////////////////////////
    task automatic t_commit();
        for (int b = 0; b < 4; b++)
        begin
            wr(smtc_pkg::ADDR_CYCLES, tv(b));
            wr(smtc_pkg::ADDR_OPMODE, om(b));
            check_banks();
            wr(smtc_pkg::ADDR_CMD, cmd(3'(b), smtc_pkg::CMD_TYPE_UPDATE));
            cyc_exp[b] = tv(b);
            opm_exp[b] = om(b);
            check_banks();
        end
    endtask : t_commit

    task automatic t_bad();
        wr(smtc_pkg::ADDR_CYCLES, tv(4));
        for (int c = 0; c < 7; c++)
        begin
            wr(smtc_pkg::ADDR_CMD, c < 4 ? cmd(3'(c + 4), 2'h2) : cmd(3'h0, 2'(c == 6 ? 3 : c - 4)));
            chk("cmd_error", 64'h1, 64'(cmd_error));
            wr(smtc_pkg::ADDR_STATUS, 32'h1);
            rd(smtc_pkg::ADDR_STATUS);
            chk("status error bit", 64'h0, 64'(rdat[0]));
        end
        rd(12'hffc);
        chk("unmapped read", 64'h0, 64'(rdat));
        check_banks();
    endtask : t_bad

    task automatic t_eff();
        for (int m = 0; m < 2; m++)
        begin
            wr(smtc_pkg::ADDR_BUSMODE, 32'(m));
            chk("mux_mode", 64'(m), 64'(mux_mode));
            for (int b = 0; b < 4; b++)
            begin
                @(posedge clock);
                bank_req <= 2'(b);
                repeat (4) @(posedge clock);
                #1;
                chk("active_eff", 64'(eff_exp(cyc_exp[b], opm_exp[b], 1'(m))), 64'(active_eff));
            end
        end
        wr(smtc_pkg::ADDR_BUSMODE, 32'h0);
        // a write while the clock enable is low must not land
        @(posedge clock);
        clk_en <= 1'b0;
        wr(smtc_pkg::ADDR_BUSMODE, 32'h1);
        chk("frozen mux_mode", 64'h0, 64'(mux_mode));
        clk_en <= 1'b1;
    endtask : t_eff

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // reset, then scenarios
    initial
    begin
        for (int b = 0; b < 4; b++)
        begin
            cyc_exp[b] = {12'h0, smtc_pkg::CYCLES_RESET};
            opm_exp[b] = {20'h0, smtc_pkg::OPMODE_RESET};
        end
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        check_banks();
        t_commit();
        t_bad();
        t_eff();
        report_and_stop();
    end
endmodule : tb_smtc_top
